// file: src/tss_regs.vh
// Constants shared by the touch screen sequencer files.
// Assumes inclusion by bare name from files under src/.
`ifndef TSS_REGS_VH
`define TSS_REGS_VH

// Core clock period and documented timings, in ns
`define TSS_CLK_NS 8
`define TSS_STEP_NS 40000
`define TSS_CONV_MAX_NS 10000

// Derived cycle counts: one delay step, longest conversion
`define TSS_STEP_CYC (`TSS_STEP_NS / `TSS_CLK_NS)
`define TSS_CONV_MAX_CYC (`TSS_CONV_MAX_NS / `TSS_CLK_NS)

// Slot action encodings
`define TSS_ACT_DUMMY 2'h0
`define TSS_ACT_X 2'h1
`define TSS_ACT_Y 2'h2
`define TSS_ACT_CONTACT 2'h3

// Converter channel map
`define TSS_CH_COIN 4'h8
`define TSS_CH_AUX_FIRST 4'h9
`define TSS_CH_AUX_LAST 4'hb
`define TSS_CH_PLATE_FIRST 4'hc

// Sense selections for the plate multiplexer
`define TSS_SENSE_Y_A 2'h0
`define TSS_SENSE_X_A 2'h1
`define TSS_SENSE_DIFF 2'h2
`define TSS_SENSE_NONE 2'h3

// Reset values
`define TSS_DLY_RST 4'h0
`define TSS_CODE_ZERO 10'h000

`endif

// file: src/tss_delay.v
// Programmable delay of 0..15 steps of 40 us.
// Assumes start is a one-cycle pulse on core_clk; done pulses once.
`timescale 1ns/1ps
`include "tss_regs.vh"

module tss_delay #(
    parameter STEP_CYC = `TSS_STEP_CYC
) (
    input wire core_clk,
    input wire rst,
    input wire start,
    input wire [3:0] code,
    output reg done
);

////////////////////////////////////////////////////////////////////////////
reg [15:0] pre_cnt;
reg [3:0] steps;
reg running;
wire step_tick;

// Step tick from a prescaler, restarted with every delay
assign step_tick = running && (pre_cnt == 16'h0000);

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        pre_cnt <= 16'h0000;
        steps <= 4'h0;
        running <= 1'b0;
        done <= 1'b0;
    end else begin
        done <= 1'b0;
        if (start) begin
            // Code zero still costs one cycle, keeping done a clean pulse
            pre_cnt <= STEP_CYC[15:0] - 16'h0001;
            steps <= code;
            running <= (code != 4'h0);
            done <= (code == 4'h0);
        end else if (running) begin
            if (step_tick) begin
                pre_cnt <= STEP_CYC[15:0] - 16'h0001;
                steps <= steps - 4'h1;
                if (steps == 4'h1) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end
            end else begin
                pre_cnt <= pre_cnt - 16'h0001;
            end
        end
    end
end

endmodule

// file: src/tss_plate.v
// Plate switch drivers for the four-wire panel.
// Assumes the analog switches follow these levels directly.
`timescale 1ns/1ps
`include "tss_regs.vh"

module tss_plate (
    input wire core_clk,
    input wire rst,
    input wire load,
    input wire release_all,
    input wire [1:0] action,
    output reg x_a_to_ref,
    output reg x_b_to_gnd,
    output reg y_a_to_ref,
    output reg y_b_to_gnd,
    output reg y_a_current,
    output reg [1:0] sense_sel
);

////////////////////////////////////////////////////////////////////////////
// Switch setting per action; a dummy leaves plates idle so the
// reference capacitor can discharge before polarity changes.
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        x_a_to_ref <= 1'b0;
        x_b_to_gnd <= 1'b0;
        y_a_to_ref <= 1'b0;
        y_b_to_gnd <= 1'b0;
        y_a_current <= 1'b0;
        sense_sel <= `TSS_SENSE_NONE;
    end else if (release_all) begin
        x_a_to_ref <= 1'b0;
        x_b_to_gnd <= 1'b0;
        y_a_to_ref <= 1'b0;
        y_b_to_gnd <= 1'b0;
        y_a_current <= 1'b0;
        sense_sel <= `TSS_SENSE_NONE;
    end else if (load) begin
        x_a_to_ref <= (action == `TSS_ACT_X);
        x_b_to_gnd <= (action == `TSS_ACT_X) ||
                      (action == `TSS_ACT_CONTACT);
        y_a_to_ref <= (action == `TSS_ACT_Y);
        y_b_to_gnd <= (action == `TSS_ACT_Y);
        y_a_current <= (action == `TSS_ACT_CONTACT);
        case (action)
            `TSS_ACT_X: sense_sel <= `TSS_SENSE_Y_A;
            `TSS_ACT_Y: sense_sel <= `TSS_SENSE_X_A;
            `TSS_ACT_CONTACT: sense_sel <= `TSS_SENSE_DIFF;
            default: sense_sel <= `TSS_SENSE_NONE;
        endcase
    end
end

endmodule

// file: src/tss_touch_seq.v
// Touch screen conversion sequencer with pen detect and result store.
// Assumes a converter core on core_clk: start pulse in, done pulse and
// 10-bit code out; control bits arrive as plain ports on core_clk.
`timescale 1ns/1ps
`include "tss_regs.vh"

module tss_touch_seq #(
    parameter STEP_CYC = `TSS_STEP_CYC,
    parameter SLOTS = 8
) (
    input wire core_clk,
    input wire rst,
    input wire touch_enable,
    input wire pen_detect_bias_enable,
    input wire [15:0] touch_slot_action,
    input wire [2:0] touch_last_slot,
    input wire [3:0] touch_first_delay,
    input wire [3:0] touch_between_delay,
    input wire [3:0] touch_after_delay,
    input wire touch_sequence_start,
    input wire pen_detect_mask,
    input wire pen_detect_clear,
    input wire touch_done_mask,
    input wire touch_done_clear,
    input wire pen_touch_pin,
    input wire norm_conv_req,
    input wire [3:0] norm_conv_channel,
    input wire [2:0] norm_conv_slot,
    input wire adc_done,
    input wire [9:0] adc_code,
    input wire [1:0] result_pair_sel,
    output reg adc_start,
    output reg [3:0] adc_channel,
    output reg adc_touch_mode,
    output reg coin_cell_scale_on,
    output reg aux_input_on,
    output reg plate_input_on,
    output reg touch_bias_reference_on,
    output reg pen_bias_on,
    output wire x_a_to_ref,
    output wire x_b_to_gnd,
    output wire y_a_to_ref,
    output wire y_b_to_gnd,
    output wire y_a_current,
    output wire [1:0] sense_sel,
    output reg pen_detect_flag,
    output reg touch_done_irq,
    output reg irq_out,
    output reg touch_busy,
    output reg conv_overtime,
    output reg [19:0] result_pair
);

////////////////////////////////////////////////////////////////////////////
// One-hot sequencer states
localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_FIRST = 6'h02;
localparam [5:0] ST_CONV = 6'h04;
localparam [5:0] ST_BETWEEN = 6'h08;
localparam [5:0] ST_AFTER = 6'h10;
localparam [5:0] ST_NORM = 6'h20;

localparam integer CONV_MAX_INT = `TSS_CONV_MAX_CYC;
localparam [10:0] CONV_MAX = CONV_MAX_INT[10:0];

reg [5:0] state;
reg [2:0] slot;
reg [2:0] last_slot;
reg [2:0] norm_slot;
reg [10:0] conv_cnt;
reg [9:0] result [0:SLOTS-1];
reg dly_start;
reg [3:0] dly_code;
reg plate_load;
reg pen_s1;
reg pen_s2;
reg pen_s3;
wire dly_done;
wire pen_rise;
wire conv_end;
wire [1:0] cur_action;
wire [9:0] store_code;
integer i;

// Action field of a given slot
function [1:0] slot_action;
    input [15:0] actions;
    input [2:0] idx;
    begin
        slot_action = actions[{idx, 1'b0} +: 2];
    end
endfunction

// Channel class: 1 coin cell, 2 aux pin, 3 plate as input, 0 other
function [1:0] chan_class;
    input [3:0] ch;
    begin
        if (ch == `TSS_CH_COIN)
            chan_class = 2'h1;
        else if (ch >= `TSS_CH_AUX_FIRST && ch <= `TSS_CH_AUX_LAST)
            chan_class = 2'h2;
        else if (ch >= `TSS_CH_PLATE_FIRST)
            chan_class = 2'h3;
        else
            chan_class = 2'h0;
    end
endfunction

assign cur_action = slot_action(touch_slot_action, slot);
// A conversion ends on the converter's done or on the 10 us limit
assign conv_end = adc_done || (conv_cnt == CONV_MAX);
assign store_code = (cur_action == `TSS_ACT_DUMMY || !adc_done) ?
                    `TSS_CODE_ZERO : adc_code;

////////////////////////////////////////////////////////////////////////////
// Shared delay timer; one delay is ever running at a time
tss_delay #(
    .STEP_CYC(STEP_CYC)
) u_delay (
    .core_clk(core_clk),
    .rst(rst),
    .start(dly_start),
    .code(dly_code),
    .done(dly_done)
);

// Plate switches, released while idle and during ordinary conversions
tss_plate u_plate (
    .core_clk(core_clk),
    .rst(rst),
    .load(plate_load),
    .release_all(state == ST_IDLE || state == ST_NORM),
    .action(cur_action),
    .x_a_to_ref(x_a_to_ref),
    .x_b_to_gnd(x_b_to_gnd),
    .y_a_to_ref(y_a_to_ref),
    .y_b_to_gnd(y_b_to_gnd),
    .y_a_current(y_a_current),
    .sense_sel(sense_sel)
);

////////////////////////////////////////////////////////////////////////////
// Pen comparator is asynchronous: two flops, then edge detect on s2
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        pen_s1 <= 1'b0;
        pen_s2 <= 1'b0;
        pen_s3 <= 1'b0;
    end else begin
        pen_s1 <= pen_touch_pin;
        pen_s2 <= pen_s1;
        pen_s3 <= pen_s2;
    end
end

// pen detect suspended while touch enabled
assign pen_rise = pen_s2 && !pen_s3 && pen_detect_bias_enable &&
                  !touch_enable;

////////////////////////////////////////////////////////////////////////////
// Main sequencer
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        state <= ST_IDLE;
        slot <= 3'h0;
        last_slot <= 3'h0;
        norm_slot <= 3'h0;
        conv_cnt <= 11'h000;
        dly_start <= 1'b0;
        dly_code <= `TSS_DLY_RST;
        plate_load <= 1'b0;
        adc_start <= 1'b0;
        adc_channel <= 4'h0;
        adc_touch_mode <= 1'b0;
        touch_busy <= 1'b0;
        conv_overtime <= 1'b0;
        touch_done_irq <= 1'b0;
        for (i = 0; i < SLOTS; i = i + 1)
            result[i] <= `TSS_CODE_ZERO;
    end else begin
        dly_start <= 1'b0;
        plate_load <= 1'b0;
        adc_start <= 1'b0;
        // Software clear; a done event below in the same cycle wins
        if (touch_done_clear)
            touch_done_irq <= 1'b0;
        case (state)
            ST_IDLE: begin
                // touch start wins over ordinary request
                if (touch_sequence_start && touch_enable) begin
                    slot <= 3'h0;
                    last_slot <= touch_last_slot;
                    dly_code <= touch_first_delay;
                    dly_start <= 1'b1;
                    touch_busy <= 1'b1;
                    conv_overtime <= 1'b0;
                    adc_touch_mode <= 1'b1;
                    state <= ST_FIRST;
                end else if (norm_conv_req) begin
                    adc_channel <= norm_conv_channel;
                    norm_slot <= norm_conv_slot;
                    adc_start <= 1'b1;
                    conv_cnt <= 11'h000;
                    conv_overtime <= 1'b0;
                    state <= ST_NORM;
                end
            end
            ST_FIRST, ST_BETWEEN: begin
                if (dly_done) begin
                    plate_load <= 1'b1;
                    adc_start <= 1'b1;
                    conv_cnt <= 11'h000;
                    state <= ST_CONV;
                end
            end
            ST_CONV: begin
                conv_cnt <= conv_cnt + 11'h001;
                if (conv_end) begin
                    if (!adc_done)
                        conv_overtime <= 1'b1;
                    result[slot] <= store_code;
                    dly_start <= 1'b1;
                    if (slot == last_slot) begin
                        dly_code <= touch_after_delay;
                        state <= ST_AFTER;
                    end else begin
                        dly_code <= touch_between_delay;
                        slot <= slot + 3'h1;
                        state <= ST_BETWEEN;
                    end
                end
            end
            ST_AFTER: begin
                if (dly_done) begin
                    touch_done_irq <= 1'b1;
                    touch_busy <= 1'b0;
                    adc_touch_mode <= 1'b0;
                    state <= ST_IDLE;
                end
            end
            ST_NORM: begin
                conv_cnt <= conv_cnt + 11'h001;
                if (adc_done || conv_cnt == CONV_MAX) begin
                    if (!adc_done)
                        conv_overtime <= 1'b1;
                    // plate channels only while touch off
                    if (adc_done && !(chan_class(adc_channel) == 2'h3 &&
                                      touch_enable))
                        result[norm_slot] <= adc_code;
                    else
                        result[norm_slot] <= `TSS_CODE_ZERO;
                    state <= ST_IDLE;
                end
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Input path selection for ordinary conversions
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        coin_cell_scale_on <= 1'b0;
        aux_input_on <= 1'b0;
        plate_input_on <= 1'b0;
    end else begin
        // coin cell scaler on channel 8
        coin_cell_scale_on <= (state == ST_NORM) &&
                              (chan_class(adc_channel) == 2'h1);
        // auxiliary pins on 9 to 11
        aux_input_on <= (state == ST_NORM) &&
                        (chan_class(adc_channel) == 2'h2);
        // plates as inputs on 12 to 15, only while touch is off
        plate_input_on <= (state == ST_NORM) && !touch_enable &&
                          (chan_class(adc_channel) == 2'h3);
    end
end

////////////////////////////////////////////////////////////////////////////
// Bias, pen flag and interrupt line
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        touch_bias_reference_on <= 1'b0;
        pen_bias_on <= 1'b0;
        pen_detect_flag <= 1'b0;
        irq_out <= 1'b0;
    end else begin
        touch_bias_reference_on <= touch_enable &&
                                   (state == ST_FIRST ||
                                    state == ST_CONV ||
                                    state == ST_BETWEEN ||
                                    state == ST_AFTER);
        // pen bias only with touch off
        pen_bias_on <= pen_detect_bias_enable && !touch_enable;
        if (pen_rise)
            pen_detect_flag <= 1'b1;
        else if (pen_detect_clear)
            pen_detect_flag <= 1'b0;
        irq_out <= (pen_detect_flag && !pen_detect_mask) ||
                   (touch_done_irq && !touch_done_mask);
    end
end

////////////////////////////////////////////////////////////////////////////
// four result registers, two slots each
always @(posedge core_clk or posedge rst) begin
    if (rst)
        result_pair <= 20'h00000;
    else
        result_pair <= {result[{result_pair_sel, 1'b1}],
                        result[{result_pair_sel, 1'b0}]};
end

endmodule

// file: dv/tss_touch_seq_assertions.sv
// Port checker for the touch screen sequencer.
// Assumes one clock domain, core_clk, with rst asynchronous active high.
`timescale 1ns/1ps
`include "tss_regs.vh"
module tss_touch_seq_assertions (
    input wire core_clk,
    input wire rst,
    input wire touch_enable,
    input wire pen_detect_bias_enable,
    input wire touch_sequence_start,
    input wire pen_detect_mask,
    input wire pen_detect_clear,
    input wire touch_done_mask,
    input wire pen_touch_pin,
    input wire adc_touch_mode,
    input wire plate_input_on,
    input wire touch_bias_reference_on,
    input wire x_a_to_ref,
    input wire x_b_to_gnd,
    input wire y_a_to_ref,
    input wire y_b_to_gnd,
    input wire y_a_current,
    input wire [1:0] sense_sel,
    input wire pen_detect_flag,
    input wire touch_done_irq,
    input wire irq_out,
    input wire touch_busy
);
default clocking cb @(posedge core_clk);
endclocking
default disable iff (rst);

////////////////////////////////////////////////////////////////////////
// Pen held long enough to clear the two-flop synchroniser
sequence pen_held;
    (pen_touch_pin && pen_detect_bias_enable && !touch_enable
        && !pen_detect_clear) [*4];
endsequence

pen_set_a: assert property (pen_held |-> ##[0:2] pen_detect_flag)
    else $error("pen flag not set after touch");
pen_block_a: assert property (touch_enable [*5] |->
    !$rose(pen_detect_flag))
    else $error("pen flag rose with touch enabled");
irq_mux_a: assert property (irq_out == $past(
    (pen_detect_flag && !pen_detect_mask)
    || (touch_done_irq && !touch_done_mask)))
    else $error("interrupt output does not follow flags");
ref_gate_a: assert property (!adc_touch_mode [*2] |->
    !touch_bias_reference_on)
    else $error("touch reference on outside touch mode");
done_busy_a: assert property ($rose(touch_done_irq) |-> !touch_busy)
    else $error("done raised while still busy");
busy_rise_a: assert property ($rose(touch_busy) |->
    $past(touch_sequence_start && touch_enable))
    else $error("sequence began without start");
x_drive_a: assert property (x_a_to_ref && x_b_to_gnd |->
    sense_sel == `TSS_SENSE_Y_A && !y_a_to_ref)
    else $error("x reading wired wrongly");
y_drive_a: assert property (y_a_to_ref && y_b_to_gnd |->
    sense_sel == `TSS_SENSE_X_A && !x_a_to_ref)
    else $error("y reading wired wrongly");
contact_a: assert property (y_a_current |-> x_b_to_gnd
    && !y_a_to_ref && sense_sel == `TSS_SENSE_DIFF)
    else $error("contact reading wired wrongly");
plate_free_a: assert property (plate_input_on |-> !touch_busy)
    else $error("plate inputs used during touch");
endmodule

bind tss_touch_seq tss_touch_seq_assertions chk (.*);

// file: dv/tss_panel_model.sv
// Converter core and four-wire panel seen from the sequencer.
// Assumes adc_start pulses on core_clk; answers after conv_lat cycles.
`timescale 1ns/1ps
module tss_panel_model (
    input wire core_clk,
    input wire rst,
    input wire adc_start,
    input wire adc_touch_mode,
    input wire [3:0] adc_channel,
    input wire [1:0] sense_sel,
    input wire pen_press,
    input wire [15:0] conv_lat,
    output reg adc_done,
    output reg [9:0] adc_code,
    output wire pen_touch_pin
);
reg [15:0] cnt;
reg busy;

////////////////////////////////////////////////////////////////////////
// Comparator shows contact only while pressed
assign pen_touch_pin = pen_press;

// answer inside the conversion limit unless told to stall
// Code names the sensed terminal in touch mode, else the channel, so routing faults show in results;
// between answers the bus toggles, as a released bus would not hold
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        busy <= 1'b0;
        cnt <= 16'h0000;
        adc_done <= 1'b0;
        adc_code <= 10'h000;
    end else begin
        adc_done <= 1'b0;
        adc_code <= ~adc_code;
        cnt <= cnt - 16'h0001;
        if (adc_start) begin
            busy <= 1'b1;
            cnt <= conv_lat;
        end else if (busy && cnt <= 16'h0001) begin
            busy <= 1'b0;
            adc_done <= 1'b1;
            if (adc_touch_mode) begin
                adc_code <= {8'h40, sense_sel};
            end else begin
                adc_code <= {6'h20, adc_channel};
            end
        end
    end
end
endmodule

// file: dv/touch_screen_adc_sequencer_tb_top.sv
// Self-checking bench for the touch screen sequencer.
// Assumes src/ on the include path and the panel model beside it.
`timescale 1ns/1ps
`include "tss_regs.vh"
module touch_screen_adc_sequencer_tb_top;
reg core_clk = 1'b0, rst = 1'b1, touch_enable = 1'b0;
reg pen_detect_bias_enable = 1'b0, touch_sequence_start = 1'b0;
reg pen_detect_mask = 1'b0, pen_detect_clear = 1'b0;
reg touch_done_mask = 1'b0, touch_done_clear = 1'b0;
reg norm_conv_req = 1'b0, pen_press = 1'b0;
reg [15:0] touch_slot_action = 16'h0000, conv_lat = 16'h0003;
reg [2:0] touch_last_slot = 3'h0, norm_conv_slot = 3'h0;
reg [3:0] touch_first_delay = 4'h0, touch_between_delay = 4'h1;
reg [3:0] touch_after_delay = 4'h2, norm_conv_channel = 4'h0;
reg [1:0] result_pair_sel = 2'h0;
wire adc_start, adc_touch_mode, coin_cell_scale_on, aux_input_on;
wire plate_input_on, touch_bias_reference_on, pen_bias_on, x_a_to_ref;
wire x_b_to_gnd, y_a_to_ref, y_b_to_gnd, y_a_current, pen_detect_flag;
wire touch_done_irq, irq_out, touch_busy, conv_overtime, adc_done;
wire pen_touch_pin;
wire [3:0] adc_channel;
wire [1:0] sense_sel;
wire [19:0] result_pair;
wire [9:0] adc_code;
reg [9:0] exp_res [0:7];
integer n_errors = 0, compares = 0, k;

tss_touch_seq #(.STEP_CYC(4)) dut (.*);
tss_panel_model panel (.*);

////////////////////////////////////////////////////////////////////////
// 125 MHz core clock
initial forever #4 core_clk = ~core_clk;

task tally_and_finish;
    begin
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    end
endtask
task timed_out;
    begin
        n_errors = n_errors + 1;
        tally_and_finish;
    end
endtask
task cmp(input [19:0] g, input [19:0] e);
    begin
        compares = compares + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("Error at %0t got %h expected %h", $time, g, e);
        end
    end
endtask
task tick(input integer n);
    repeat (n) @(negedge core_clk);
endtask
// Touch codes: dummy reads zero, else the model's sensed terminal
function [9:0] exp_code(input [1:0] a);
    exp_code = (a == `TSS_ACT_DUMMY) ? 10'h000 : {8'h40, a - 2'h1};
endfunction
task chk_pairs;
    integer j;
    begin
        for (j = 0; j < 4; j = j + 1) begin
            result_pair_sel = j[1:0];
            tick(2);
            cmp(result_pair, {exp_res[2*j+1], exp_res[2*j]});
        end
    end
endtask

////////////////////////////////////////////////////////////////////////
// Full touch run with a restart and an ordinary request in mid-run
task run_touch(input [15:0] a, input [2:0] last, input [3:0] d1);
    integer i, n_conv, t_first;
    begin
        touch_slot_action = a;
        touch_last_slot = last;
        touch_first_delay = d1;
        touch_sequence_start = 1'b1;
        tick(1);
        touch_sequence_start = 1'b0;
        n_conv = 0;
        t_first = 0;
        for (i = 1; i < 5000 && touch_done_irq !== 1'b1; i = i + 1) begin
            tick(1);
            if (adc_start === 1'b1) begin
                n_conv = n_conv + 1;
                if (t_first == 0) t_first = i;
            end
            touch_sequence_start = (i == 5);
            norm_conv_req = (i == 7);
            if (i == 4) cmp(touch_bias_reference_on, 1'b1);
        end
        if (touch_done_irq !== 1'b1) timed_out;
        cmp(n_conv[19:0], {17'h0, last} + 20'h1);
        cmp(t_first >= d1 * 4 + 2 && t_first <= d1 * 4 + 5, 1'b1);
        cmp(touch_busy, 1'b0);
        for (i = 0; i <= last; i = i + 1) exp_res[i] = exp_code(a[2*i +: 2]);
        tick(1);
        cmp(irq_out, !touch_done_mask);
        touch_done_clear = 1'b1;
        tick(1);
        touch_done_clear = 1'b0;
        tick(2);
        cmp({touch_done_irq, irq_out, touch_bias_reference_on}, 3'h0);
    end
endtask

// Ordinary conversion of one channel, with touch enabled or not
task norm_conv(input [3:0] ch);
    integer i;
    begin
        norm_conv_channel = ch;
        norm_conv_slot = ch[2:0];
        norm_conv_req = 1'b1;
        tick(1);
        norm_conv_req = 1'b0;
        cmp({adc_start, adc_channel}, {1'b1, ch});
        tick(1);
        // Plate inputs only serve as channels while touch is off
        cmp({coin_cell_scale_on, aux_input_on, plate_input_on},
            (ch == 4'h8) ? 3'h4 : (ch < 4'hc) ? 3'h2 :
            {2'h0, !touch_enable});
        for (i = 0; i < 100 && adc_done !== 1'b1; i = i + 1) tick(1);
        if (adc_done !== 1'b1) timed_out;
        tick(1);
        exp_res[ch[2:0]] = (ch >= 4'hc && touch_enable) ? 10'h000 :
                           {6'h20, ch};
    end
endtask

// Pen flag, its mask, and suspension while touch is enabled
task pen_check;
    begin
        touch_enable = 1'b0;
        pen_detect_bias_enable = 1'b1;
        pen_press = 1'b1;
        tick(8);
        cmp({pen_bias_on, pen_detect_flag, irq_out}, 3'h7);
        pen_detect_mask = 1'b1;
        tick(2);
        cmp({pen_detect_flag, irq_out}, 2'h2);
        pen_press = 1'b0;
        tick(4);
        pen_detect_clear = 1'b1;
        tick(1);
        pen_detect_clear = 1'b0;
        pen_detect_mask = 1'b0;
        touch_enable = 1'b1;
        pen_press = 1'b1;
        tick(8);
        cmp({pen_bias_on, pen_detect_flag, irq_out}, 3'h0);
        pen_press = 1'b0;
    end
endtask

////////////////////////////////////////////////////////////////////////
// Main sequence
initial begin
    for (k = 0; k < 8; k = k + 1) exp_res[k] = 10'h000;
    repeat (5) @(posedge core_clk);
    tick(1);
    rst = 1'b0;
    tick(2);
    cmp({adc_start, adc_touch_mode, coin_cell_scale_on, aux_input_on,
        plate_input_on, touch_bias_reference_on, pen_bias_on, x_a_to_ref,
        x_b_to_gnd, y_a_to_ref, y_b_to_gnd, y_a_current, pen_detect_flag,
        touch_done_irq, irq_out, touch_busy, conv_overtime, sense_sel},
        {17'h0, 2'h3});
    chk_pairs;
    touch_enable = 1'b1;
    run_touch(16'h5539, 3'h2, 4'h3);
    chk_pairs;
    run_touch(16'he4e4, 3'h7, 4'h0);
    chk_pairs;
    pen_check;
    touch_enable = 1'b0;
    for (k = 8; k < 16; k = k + 1) norm_conv(k[3:0]);
    chk_pairs;
    touch_enable = 1'b1;
    touch_done_mask = 1'b1;
    conv_lat = 16'h0514;
    run_touch(16'h0001, 3'h0, 4'h0);
    exp_res[0] = 10'h000;
    cmp(conv_overtime, 1'b1);
    // Plate channel asked for while touch is on must store zero
    conv_lat = 16'h0003;
    norm_conv(4'hd);
    chk_pairs;
    tally_and_finish;
end
endmodule
